// ===== rtl/dcser_pkg.sv
// Package of constants and types for the disk controller status and fault-cause registers.
package dcser_pkg;

    // Register byte offsets on the Wishbone bus.
    localparam logic [3:0] DCSER_OFS_COND  = 4'h0;
    localparam logic [3:0] DCSER_OFS_CAUSE = 4'h4;
    localparam logic [3:0] DCSER_OFS_ISTAT = 4'h8;
    localparam logic [3:0] DCSER_OFS_IEN   = 4'hC;
    localparam logic [3:0] DCSER_OFS_ICLR  = 4'hC;

    // Condition register bit positions.
    localparam int DCSER_BIT_READY = 6;
    localparam int DCSER_BIT_WFLT  = 5;
    localparam int DCSER_BIT_SEEK  = 4;
    localparam int DCSER_BIT_XFER  = 3;
    localparam int DCSER_BIT_CORRECTED_FLAG  = 2;
    localparam int DCSER_BIT_FAIL  = 0;

    // Fault-cause register bit positions.
    localparam int DCSER_BIT_MARK  = 7;
    localparam int DCSER_BIT_UNREC = 6;
    localparam int DCSER_BIT_IDMIS = 4;
    localparam int DCSER_BIT_REJ   = 2;
    localparam int DCSER_BIT_HOME  = 1;

    // Mask of fault-cause bits that exist; the rest read zero.
    localparam logic [7:0] DCSER_CAUSE_MASK = 8'hD6;

    // Reset values.
    localparam logic [7:0] DCSER_RST_BYTE = 8'h00;
    localparam logic [2:0] DCSER_RST_IRQ  = 3'h0;

    // Interrupt event bit positions.
    localparam int DCSER_IRQ_DONE  = 0;
    localparam int DCSER_IRQ_FAIL  = 1;
    localparam int DCSER_IRQ_XFER  = 2;

    // Live drive conditions sampled every cycle.
    typedef struct packed {
        logic ready;
        logic wfault;
        logic seek_ok;
        logic xfer_req;
    } dcser_live_t;

    // Outcome of a finished command, valid with cmd_done.
    typedef struct packed {
        logic corrected;
        logic failed;
        logic bad_mark;
        logic unrec;
        logic id_missing;
        logic rejected;
        logic home_missing;
    } dcser_result_t;

endpackage

// ===== rtl/dcser_wb_slave.sv
// Wishbone classic slave decode with a single registered acknowledge.
`timescale 1ns/10ps
module dcser_wb_slave
    import dcser_pkg::*;
(
    input  wire logic       mclk,     // System clock.
    input  wire logic       rstn,     // Synchronous reset, active low.
    input  wire logic       wb_cyc,   // Bus cycle.
    input  wire logic       wb_stb,   // Strobe.
    output logic            wb_ack,   // Acknowledge, one cycle.
    output logic            acc_go    // Access is taken this cycle.
);

    // A request is taken on the first cycle it is seen, acked the next.
    assign acc_go = wb_cyc & wb_stb & ~wb_ack;

    // Acknowledge register, dropped in the cycle after it was given.
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            wb_ack <= 1'b0;
        end else begin
            wb_ack <= acc_go;
        end
    end

endmodule

// ===== rtl/dcser_irq.sv
// Sticky interrupt status with enable and write-one-to-clear.
`timescale 1ns/10ps
module dcser_irq
    import dcser_pkg::*;
#(
    parameter int N = 3   // Number of event sources.
)
(
    input  wire logic         mclk,     // System clock.
    input  wire logic         rstn,     // Synchronous reset, active low.
    input  wire logic [N-1:0] events,   // One-cycle event pulses.
    input  wire logic [N-1:0] clr,      // Clear strobes, one cycle.
    input  wire logic         en_we,    // Enable register write.
    input  wire logic [N-1:0] en_wd,    // Enable write data.
    output logic      [N-1:0] status,   // Sticky status.
    output logic      [N-1:0] enable,   // Enable register.
    output logic              irq       // Level interrupt.
);

    // Set wins over clear in the same cycle.
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            status <= '0;
            enable <= '0;
        end else begin
            status <= (status & ~clr) | events;
            if (en_we) begin
                enable <= en_wd;
            end
        end
    end

    // Interrupt is high while any enabled bit is set.
    assign irq = |(status & enable);

endmodule

// ===== rtl/dcser_regs.sv
// Status and fault-cause register bank of the disk controller.
// Overview of operation
// - Condition bit 6 reads 1 when drive can accept commands, else 0.
// - Condition bit 5 reads 1 while a drive write fault exists.
// - Condition bit 4 reads 1 when heads are settled over a track.
// - Condition bit 3 reads 1 when the drive is ready to move data.
// - Condition bit 2 reads 1 when a correctable error was corrected.
// - Condition bit 0 reads 1 when the previous command ended in error.
// - Fault-cause bit 7 set when a bad block mark is detected.
// - Fault-cause bit 6 set on an uncorrectable data error.
// - Fault-cause bit 4 set when the sector ID field is missing.
// - Fault-cause bit 2 set on illegal command or drive status error.
// - Fault-cause bit 1 set when recalibrate fails to find track 0.
//
// Design decisions made here: the register offsets and the Wishbone register port.
`timescale 1ns/10ps
module dcser_regs
    import dcser_pkg::*;
(
    input  wire logic          mclk,      // System clock, 200 MHz.
    input  wire logic          rstn,      // Synchronous reset, active low.
    input  wire logic          wb_cyc,    // Wishbone cycle.
    input  wire logic          wb_stb,    // Wishbone strobe.
    input  wire logic          wb_we,     // Wishbone write enable.
    input  wire logic [3:0]    wb_adr,    // Wishbone byte address.
    input  wire logic [3:0]    wb_sel,    // Wishbone byte selects.
    input  wire logic [31:0]   wb_dat_i,  // Wishbone write data.
    output logic      [31:0]   wb_dat_o,  // Wishbone read data.
    output logic               wb_ack,    // Wishbone acknowledge.
    input  wire dcser_live_t   live,      // Live drive conditions.
    input  wire logic          cmd_done,  // Command finished, one cycle.
    input  wire dcser_result_t result,    // Outcome of that command.
    output logic               irq        // Level interrupt.
);

    logic               acc_go;
    logic [7:0]         cond;
    logic [7:0]         cause;
    logic               corrected_flag_flag;
    logic               fail_flag;
    logic [2:0]         istat;
    logic [2:0]         ien;
    logic [2:0]         ievents;
    logic [7:0]         next_cause;
    logic [7:0]         rd_byte;
    wire                wr_go;
    wire                low_lane;

    // Bus handshake handled by the slave helper.
    dcser_wb_slave u_wb (
        .mclk   (mclk),
        .rstn   (rstn),
        .wb_cyc (wb_cyc),
        .wb_stb (wb_stb),
        .wb_ack (wb_ack),
        .acc_go (acc_go)
    );

    assign wr_go    = acc_go & wb_we;
    assign low_lane = wb_sel[0];

    // cause assembly
    // Fault-cause bits come straight from the command outcome.
    assign next_cause[DCSER_BIT_MARK]  = result.bad_mark;
    assign next_cause[DCSER_BIT_UNREC] = result.unrec;
    assign next_cause[DCSER_BIT_IDMIS] = result.id_missing;
    assign next_cause[DCSER_BIT_REJ]   = result.rejected;
    assign next_cause[DCSER_BIT_HOME]  = result.home_missing;
    assign next_cause[5] = 1'b0;
    assign next_cause[3] = 1'b0;
    assign next_cause[0] = 1'b0;

    // joint update
    // Outcome flags and the cause byte are captured on the same edge.
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            cause     <= DCSER_RST_BYTE;
            corrected_flag_flag <= 1'b0;
            fail_flag <= 1'b0;
        end else if (cmd_done) begin
            cause     <= next_cause & DCSER_CAUSE_MASK;
            corrected_flag_flag <= result.corrected;
            fail_flag <= result.failed;
        end
    end

    // cond assembly
    // Condition byte: live bits plus the latched command outcome.
    assign cond[7]               = 1'b0;
    assign cond[DCSER_BIT_READY] = live.ready;
    assign cond[DCSER_BIT_WFLT]  = live.wfault;
    assign cond[DCSER_BIT_SEEK]  = live.seek_ok;
    assign cond[DCSER_BIT_XFER]  = live.xfer_req;
    assign cond[DCSER_BIT_CORRECTED_FLAG]  = corrected_flag_flag;
    assign cond[1]               = 1'b0;
    assign cond[DCSER_BIT_FAIL]  = fail_flag;

    // Events: command done, command failed, transfer request rising.
    logic xfer_q;
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            xfer_q <= 1'b0;
        end else begin
            xfer_q <= live.xfer_req;
        end
    end
    assign ievents[DCSER_IRQ_DONE] = cmd_done;
    assign ievents[DCSER_IRQ_FAIL] = cmd_done & result.failed;
    assign ievents[DCSER_IRQ_XFER] = live.xfer_req & ~xfer_q;

    // Interrupt status, enable and clear.
    dcser_irq #(.N(3)) u_irq (
        .mclk   (mclk),
        .rstn   (rstn),
        .events (ievents),
        .clr    ((wr_go && low_lane && wb_adr == DCSER_OFS_ICLR && wb_dat_i[31])
                 ? wb_dat_i[2:0] : 3'h0),
        .en_we  (wr_go && low_lane && wb_adr == DCSER_OFS_IEN && !wb_dat_i[31]),
        .en_wd  (wb_dat_i[2:0]),
        .status (istat),
        .enable (ien),
        .irq    (irq)
    );

    // Read selection; unmapped offsets read zero.
    assign rd_byte = (wb_adr == DCSER_OFS_COND)  ? cond  :
                     (wb_adr == DCSER_OFS_CAUSE) ? cause :
                     (wb_adr == DCSER_OFS_ISTAT) ? {5'h00, istat} :
                     (wb_adr == DCSER_OFS_IEN)   ? {5'h00, ien} : 8'h00;

    // Read data register, loaded when a read is taken.
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (acc_go && !wb_we) begin
            wb_dat_o <= {24'h000000, rd_byte};
        end
    end

    // Named steps that the checks below are built from.
    // A read is taken when the helper reports a fresh access without write enable.
    sequence read_taken_s;
        acc_go && !wb_we;
    endsequence

    // A write is taken on the same kind of edge with write enable high.
    sequence write_taken_s;
        acc_go && wb_we;
    endsequence

    // A command ends on the single cycle of its done pulse.
    sequence cmd_end_s;
        cmd_done;
    endsequence

    // The answer to a taken access is an acknowledge lasting one cycle.
    sequence ack_pulse_s;
        wb_ack ##1 !wb_ack;
    endsequence

    // Checks of the latched command outcome.
    // same-edge update
    joint_update_a: assert property (@(posedge mclk) disable iff (!rstn)
        cmd_done |=> (cond[0] == $past(result.failed))
                     && (cause[DCSER_BIT_REJ] == $past(result.rejected)))
        else $error("cause and failed flag not updated together");

    unused_zero_a: assert property (@(posedge mclk) disable iff (!rstn)
        (cause & ~DCSER_CAUSE_MASK) == 8'h00)
        else $error("unused cause bits nonzero");

    mark_cap_a: assert property (@(posedge mclk) disable iff (!rstn)
        cmd_done && result.bad_mark |=> cause[7])
        else $error("bad mark not captured");

    home_cap_a: assert property (@(posedge mclk) disable iff (!rstn)
        cmd_done && !result.home_missing |=> !cause[1])
        else $error("home flag not cleared");

    fail_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
        !cmd_done |=> $stable(fail_flag))
        else $error("failed flag changed without command end");

    unrec_cap_a: assert property (@(posedge mclk) disable iff (!rstn)
        cmd_done |=> cause[6] == $past(result.unrec))
        else $error("unrecoverable flag wrong");

    corrected_flag_cap_a: assert property (@(posedge mclk) disable iff (!rstn)
        cmd_end_s |=> cond[DCSER_BIT_CORRECTED_FLAG] == $past(result.corrected))
        else $error("corrected flag not captured");

    corrected_flag_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
        !cmd_done |=> $stable(corrected_flag_flag))
        else $error("corrected flag changed without command end");

    fail_cap_a: assert property (@(posedge mclk) disable iff (!rstn)
        cmd_end_s |=> cond[DCSER_BIT_FAIL] == $past(result.failed))
        else $error("failed flag not captured");

    mark_clear_a: assert property (@(posedge mclk) disable iff (!rstn)
        cmd_done && !result.bad_mark |=> !cause[DCSER_BIT_MARK])
        else $error("bad mark flag not cleared");

    idmis_cap_a: assert property (@(posedge mclk) disable iff (!rstn)
        cmd_end_s |=> cause[DCSER_BIT_IDMIS] == $past(result.id_missing))
        else $error("missing ID flag wrong");

    rej_cap_a: assert property (@(posedge mclk) disable iff (!rstn)
        cmd_end_s |=> cause[DCSER_BIT_REJ] == $past(result.rejected))
        else $error("rejected flag wrong");

    home_set_a: assert property (@(posedge mclk) disable iff (!rstn)
        cmd_done && result.home_missing |=> cause[DCSER_BIT_HOME])
        else $error("home flag not set");

    cause_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
        !cmd_done |=> $stable(cause))
        else $error("cause changed without command end");

    cause_write_a: assert property (@(posedge mclk) disable iff (!rstn)
        write_taken_s ##0 (wb_adr == DCSER_OFS_CAUSE && !cmd_done) |=> $stable(cause))
        else $error("write changed the cause byte");

    // Checks of the live condition bits.
    // ready reflects live
    ready_live_a: assert property (@(posedge mclk) disable iff (!rstn)
        cond[6] == live.ready)
        else $error("ready bit wrong");

    wfault_live_a: assert property (@(posedge mclk) disable iff (!rstn)
        cond[DCSER_BIT_WFLT] == live.wfault)
        else $error("write fault bit wrong");

    seek_live_a: assert property (@(posedge mclk) disable iff (!rstn)
        cond[DCSER_BIT_SEEK] == live.seek_ok)
        else $error("seek settled bit wrong");

    xfer_live_a: assert property (@(posedge mclk) disable iff (!rstn)
        cond[DCSER_BIT_XFER] == live.xfer_req)
        else $error("transfer request bit wrong");

    // The busy and index positions are not modelled and must read zero.
    spare_cond_a: assert property (@(posedge mclk) disable iff (!rstn)
        !cond[7] && !cond[1])
        else $error("spare condition bits nonzero");

    // Checks of the bus handshake and read path.
    // Ack timing.
    ack_once_a: assert property (@(posedge mclk) disable iff (!rstn)
        wb_ack |=> !wb_ack)
        else $error("ack longer than one cycle");

    // Every taken access is answered in the next cycle, once.
    ack_after_take_a: assert property (@(posedge mclk) disable iff (!rstn)
        acc_go |=> ack_pulse_s)
        else $error("taken access not acknowledged");

    // An acknowledge never appears without a taken access before it.
    ack_cause_a: assert property (@(posedge mclk) disable iff (!rstn)
        wb_ack |-> $past(acc_go))
        else $error("ack without a request");

    // Read data stand with the acknowledge.
    read_data_a: assert property (@(posedge mclk) disable iff (!rstn)
        read_taken_s |=> wb_dat_o == {24'h000000, $past(rd_byte)})
        else $error("read data wrong");

    // Read data hold until the next read is taken.
    read_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
        !(acc_go && !wb_we) |=> $stable(wb_dat_o))
        else $error("read data changed without a read");

    // The registers are one byte wide, so the upper lanes read zero.
    upper_zero_a: assert property (@(posedge mclk) disable iff (!rstn)
        wb_dat_o[31:8] == 24'h000000)
        else $error("upper read lanes nonzero");

    // Checks of the interrupt status and enable.
    // A finished command always leaves its sticky status bit.
    done_sticky_a: assert property (@(posedge mclk) disable iff (!rstn)
        cmd_done |=> istat[DCSER_IRQ_DONE])
        else $error("done status not set");

    // A failed command sets its status bit even against a clear.
    fail_sticky_a: assert property (@(posedge mclk) disable iff (!rstn)
        cmd_done && result.failed |=> istat[DCSER_IRQ_FAIL])
        else $error("fail status not set");

    // The done bit stays set until software clears it.
    sticky_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
        istat[DCSER_IRQ_DONE] && !(wr_go && low_lane && wb_adr == DCSER_OFS_ICLR
            && wb_dat_i[31] && wb_dat_i[DCSER_IRQ_DONE]) |=> istat[DCSER_IRQ_DONE])
        else $error("done status lost");

    // A rising transfer request sets its status bit.
    xfer_event_a: assert property (@(posedge mclk) disable iff (!rstn)
        live.xfer_req && !xfer_q |=> istat[DCSER_IRQ_XFER])
        else $error("transfer status not set");

    // A clear without a new event removes the status bit.
    clear_works_a: assert property (@(posedge mclk) disable iff (!rstn)
        wr_go && low_lane && wb_adr == DCSER_OFS_ICLR && wb_dat_i[31]
            && wb_dat_i[DCSER_IRQ_FAIL] && !cmd_done |=> !istat[DCSER_IRQ_FAIL])
        else $error("fail status not cleared");

    // An enable write loads the enable register.
    enable_write_a: assert property (@(posedge mclk) disable iff (!rstn)
        wr_go && low_lane && wb_adr == DCSER_OFS_IEN && !wb_dat_i[31]
            |=> ien == $past(wb_dat_i[2:0]))
        else $error("enable register not written");

    // An enabled, set status bit raises the interrupt.
    irq_follow_a: assert property (@(posedge mclk) disable iff (!rstn)
        istat[DCSER_IRQ_FAIL] && ien[DCSER_IRQ_FAIL] |-> irq)
        else $error("interrupt not raised");

    // Reset leaves the bus quiet and the outcome registers empty.
    reset_quiet_a: assert property (@(posedge mclk)
        !rstn |=> !wb_ack && (cause == DCSER_RST_BYTE) && !irq)
        else $error("state not cleared by reset");

endmodule

// ===== verif/dcser_drive_model.sv
// Behavioural drive mechanism that finishes commands and reports their outcome.
`timescale 1ns/10ps
module dcser_drive_model
    import dcser_pkg::*;
(
    input  wire logic          mclk,      // System clock.
    input  wire logic          rstn,      // Synchronous reset, active low.
    input  wire logic          go,        // Start a command, one cycle.
    input  wire dcser_result_t want,      // Outcome to report for it.
    output logic               cmd_done,  // Command finished, one cycle.
    output dcser_result_t      result,    // Outcome, valid with cmd_done.
    output logic               busy       // Command in progress.
);
    logic [2:0]    cnt;
    dcser_result_t held;

    // Counts down a short latency, then pulses done; the outcome toggles when not valid.
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            cnt      <= 3'h0;
            cmd_done <= 1'b0;
            held     <= '0;
            result   <= '0;
        end else begin
            cmd_done <= (cnt == 3'h1);
            result   <= (cnt == 3'h1) ? held : ~result;
            if (go) begin
                cnt  <= 3'h4;
                held <= want;
            end else if (cnt != 3'h0) begin
                cnt <= cnt - 3'h1;
            end
        end
    end

    // The command counts as running until its done pulse has passed.
    assign busy = (cnt != 3'h0) || cmd_done;
endmodule

// ===== verif/dcser_regs_test.sv
// Self-checking testbench of the disk controller status and fault-cause registers.
`timescale 1ns/10ps
module dcser_regs_test import dcser_pkg::*;;
    logic          mclk = 1'b0, rstn = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
    logic          wb_ack, irq, cmd_done, busy, go = 1'b0;
    logic [3:0]    wb_adr = 4'h0, wb_sel = 4'h0;
    logic [31:0]   wb_dat_i = 32'h0, wb_dat_o, q;
    dcser_live_t   live = '0;
    dcser_result_t want = '0, result;
    int            num_errors = 0, checks_done = 0, cycles = 0;

    dcser_regs dcser_regs_i (.mclk(mclk), .rstn(rstn), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
        .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack(wb_ack), .live(live), .cmd_done(cmd_done),
        .result(result), .irq(irq));
    dcser_drive_model dcser_drive_model_i (.mclk(mclk), .rstn(rstn), .go(go), .want(want),
        .cmd_done(cmd_done), .result(result), .busy(busy));

    // The clock toggles every half period of 2.5 ns.
    always #2.5 mclk = ~mclk;

    // A hang is cut short after a fixed number of cycles.
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            num_errors++;
            complete_run();
        end
    end

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    // One classic Wishbone cycle, held until ack is sampled high.
    task automatic bus(input logic we, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        wb_cyc <= 1'b1; wb_stb <= 1'b1; wb_we <= we; wb_adr <= a; wb_dat_i <= d;
        wb_sel <= 4'hF;
        do begin
            @(posedge mclk);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        q = wb_dat_o;
        if (n >= 20) chk("ack", 32'h1, 32'h0);
        wb_cyc <= 1'b0; wb_stb <= 1'b0; wb_we <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string name);
        bus(1'b0, a, 32'h0);
        chk(name, exp, q);
    endtask

    // Starts one drive command and waits until its outcome has been delivered.
    task automatic cmd(input logic [6:0] r);
        int n;
        n = 0;
        @(posedge mclk);
        go <= 1'b1; want <= r;
        @(posedge mclk);
        go <= 1'b0;
        do begin
            @(posedge mclk);
            n++;
        end while (busy && n < 20);
    endtask

    task automatic t_reset();
        rd(DCSER_OFS_COND, 32'h0, "cond");
        rd(DCSER_OFS_CAUSE, 32'h0, "cause");
        rd(DCSER_OFS_ISTAT, 32'h0, "istat");
        rd(DCSER_OFS_IEN, 32'h0, "ien");
        rd(4'h6, 32'h0, "unmapped");
    endtask

    task automatic t_live();
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk);
            live <= dcser_live_t'(4'h8 >> i);
            rd(DCSER_OFS_COND, 32'h40 >> i, "cond live");
        end
        live <= '0;
        rd(DCSER_OFS_COND, 32'h0, "cond idle");
        rd(DCSER_OFS_ISTAT, 32'h4, "istat xfer");
    endtask

    task automatic t_cmds();
        logic [6:0] rs [8] = '{7'h40, 7'h30, 7'h28, 7'h24, 7'h22, 7'h21, 7'h00, 7'h3F};
        logic [7:0] ec [8] = '{8'h04, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h00, 8'h01};
        logic [7:0] ek [8] = '{8'h00, 8'h80, 8'h40, 8'h10, 8'h04, 8'h02, 8'h00, 8'hD6};
        for (int i = 0; i < 8; i++) begin
            cmd(rs[i]);
            rd(DCSER_OFS_COND, {24'h0, ec[i]}, "cond cmd");
            rd(DCSER_OFS_CAUSE, {24'h0, ek[i]}, "cause cmd");
        end
        bus(1'b1, DCSER_OFS_CAUSE, 32'hFF);
        rd(DCSER_OFS_CAUSE, 32'hD6, "cause write");
    endtask

    task automatic t_irq();
        bus(1'b1, DCSER_OFS_ICLR, 32'h8000_0007);
        bus(1'b1, DCSER_OFS_IEN, 32'h2);
        rd(DCSER_OFS_IEN, 32'h2, "ien");
        chk("irq idle", 32'h0, {31'h0, irq});
        cmd(7'h20);
        chk("irq fail", 32'h1, {31'h0, irq});
        rd(DCSER_OFS_ISTAT, 32'h3, "istat fail");
        bus(1'b1, DCSER_OFS_ICLR, 32'h8000_0002);
        chk("irq clear", 32'h0, {31'h0, irq});
        rd(DCSER_OFS_ISTAT, 32'h1, "istat clear");
        bus(1'b1, DCSER_OFS_ICLR, 32'h8000_0001);
        cmd(7'h00);
        rd(DCSER_OFS_ISTAT, 32'h1, "istat ok");
        bus(1'b1, DCSER_OFS_IEN, 32'h0);
        cmd(7'h20);
        chk("irq masked", 32'h0, {31'h0, irq});
        rd(DCSER_OFS_ISTAT, 32'h3, "istat masked");
    endtask

    // Main sequence: reset for twelve cycles, then each scenario in turn.
    initial begin
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        t_reset();
        t_live();
        t_cmds();
        t_irq();
        complete_run();
    end
endmodule
